//--- output_on_off_delay_sequencer.sv
/*
 * output on/off delay sequencer for a three-channel supply.
 * assumes a command decoder drives the one-cycle write strobes and reads the
 * status outputs for queries; the analogue stages follow channel_output_o.
 */
// How it works
// [RULE1] reference select accepts 1..3 only; others are refused with an error pulse
// [RULE2] programmed reference channel is shown on a status output
// [RULE3] host sends participant channel numbers as separate arguments; the code takes the set as one bit mask on part_value_i
// [RULE4] fewer than two participants, or reference missing, is refused
// [RULE5] participant set is shown on a status output
// [RULE6] participant clear strobe drops every channel from the sequence
// [RULE7] host programs zero delay for reference and non-participants
// [RULE8] host supplies delays in ascending channel order
// [RULE9] delays count milliseconds from the reference transition
// [RULE10] each channel's programmed delay is shown on a status output
// [RULE11] direction 1 turns followers on, 0 turns them off
// [RULE12] programmed direction is shown on a status output
// [RULE13] reference switched on in on-direction starts delayed turn-on
// [RULE14] reference switched off in off-direction starts delayed turn-off
// [RULE15] non-participating channels never change on a reference transition
// [RULE16] one-millisecond tick drives per-channel down-counters loaded at the transition
`timescale 1ns/1ps
`default_nettype none
module output_on_off_delay_sequencer
    import delay_seq_pkg::*;
(
    input  wire logic                        mclk_i,
    input  wire logic                        reset_i,
    input  wire logic                        ref_write_i,
    input  wire logic [1:0]                  ref_value_i,
    input  wire logic                        part_write_i,
    input  wire logic [NUM_CH-1:0]           part_value_i,
    input  wire logic                        part_clear_i,
    input  wire logic                        delay_write_i,
    input  wire logic [NUM_CH*DELAY_W-1:0]   delay_value_i,
    input  wire logic                        dir_write_i,
    input  wire logic                        dir_value_i,
    input  wire logic                        switch_write_i,
    input  wire logic [1:0]                  switch_channel_i,
    input  wire logic                        switch_value_i,
    output logic [1:0]                       sequence_reference_o,
    output logic [NUM_CH-1:0]                sequence_participant_o,
    output logic [NUM_CH*DELAY_W-1:0]        channel_delay_o,
    output logic                             sequence_direction_o,
    output logic [NUM_CH-1:0]                channel_output_o,
    output logic [NUM_CH-1:0]                channel_pending_o,
    output logic                             command_error_o
);
    logic [1:0]              ref_r;
    logic [NUM_CH-1:0]       part_r;
    logic [DELAY_W-1:0]      delay_r [NUM_CH];
    logic                    dir_r;
    logic [NUM_CH-1:0]       out_r;
    logic [NUM_CH-1:0]       pend_r;
    logic [DELAY_W-1:0]      cnt_r   [NUM_CH];
    logic                    tick;
    logic                    ref_valid;
    logic                    part_valid;
    logic                    ref_switch;
    logic                    start_seq;

    // channel number (1..3) to one-hot; used by several decoders
    function automatic logic [NUM_CH-1:0] ch_onehot(input logic [1:0] ch);
        logic [NUM_CH-1:0] v;
        v = '0;
        if (ch >= REF_MIN && ch <= REF_MAX) begin
            v = NUM_CH'(1) << (ch - REF_MIN);
        end
        return v;
    endfunction

    function automatic int popcount(input logic [NUM_CH-1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < NUM_CH; i++) begin
            n += int'(v[i]);
        end
        return n;
    endfunction

    assign ref_valid  = (ref_value_i >= REF_MIN) && (ref_value_i <= REF_MAX); // RULE1
    // reference must be a member and at least two channels take part
    assign part_valid = (popcount(part_value_i) >= MIN_PART)
                        && ((part_value_i & ch_onehot(ref_r)) != '0); // RULE4
    // a real transition of the reference in the programmed direction
    assign ref_switch = switch_write_i && (switch_channel_i == ref_r)
                        && (out_r[ref_r - REF_MIN] != switch_value_i);
    assign start_seq  = ref_switch && (switch_value_i == dir_r)
                        && ((part_r & ch_onehot(ref_r)) != '0); // RULE13 RULE14

    // one shared divider; restarting it at the transition keeps each delay exact to within two clocks
    ms_tick_gen u_tick (
        .mclk_i    (mclk_i),
        .reset_i   (reset_i),
        .restart_i (start_seq),
        .tick_o    (tick)
    ); // RULE16

    // reference channel store; invalid values leave the old one in place
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ref_r <= REF_RESET;
        end else if (ref_write_i && ref_valid) begin
            ref_r <= ref_value_i; // RULE1
        end
    end

    // participant set; clear wins since it drops every channel at once
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            part_r <= PART_RESET;
        end else if (part_clear_i) begin
            part_r <= '0; // RULE6
        end else if (part_write_i && part_valid) begin
            part_r <= part_value_i; // RULE4
        end
    end

    // direction flag
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            dir_r <= DIR_RESET;
        end else if (dir_write_i) begin
            dir_r <= dir_value_i; // RULE11
        end
    end

    // refusal pulse for a bad reference or a participant set that is undersized or lacks the reference
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            command_error_o <= 1'b0;
        end else begin
            command_error_o <= (ref_write_i && !ref_valid)
                               || (part_write_i && !part_clear_i && !part_valid);
        end
    end

    // one copy of store, counter and switch per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            // delay store; values are milliseconds, zero for the reference by host convention
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    delay_r[g] <= DELAY_ZERO;
                end else if (delay_write_i) begin
                    delay_r[g] <= delay_value_i[g*DELAY_W +: DELAY_W]; // RULE9
                end
            end

            // down-counter per follower, loaded at the reference transition
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    pend_r[g] <= 1'b0;
                    cnt_r[g]  <= DELAY_ZERO;
                end else if (start_seq && part_r[g]
                             && (g != int'(ref_r - REF_MIN))) begin
                    pend_r[g] <= 1'b1; // RULE16
                    cnt_r[g]  <= delay_r[g];
                end else if (pend_r[g] && cnt_r[g] == DELAY_ZERO) begin
                    pend_r[g] <= 1'b0;
                end else if (pend_r[g] && tick) begin
                    cnt_r[g]  <= cnt_r[g] - 1'b1; // RULE9
                end
            end

            // output switch: direct command, or expiry of this channel's delay
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    out_r[g] <= 1'b0;
                end else if (switch_write_i && switch_channel_i == 2'(g) + REF_MIN) begin
                    out_r[g] <= switch_value_i;
                end else if (pend_r[g] && cnt_r[g] == DELAY_ZERO) begin
                    out_r[g] <= dir_r; // RULE13 RULE14 RULE15
                end
            end

            assign channel_delay_o[g*DELAY_W +: DELAY_W] = delay_r[g]; // RULE10
        end
    endgenerate

    // status outputs are the stores themselves, so a query sees a write one cycle later
    assign sequence_reference_o   = ref_r;  // RULE2
    assign sequence_participant_o = part_r; // RULE5
    assign sequence_direction_o   = dir_r;  // RULE12
    assign channel_output_o       = out_r;
    assign channel_pending_o      = pend_r;

    // stored settings: refused writes keep the old value and pulse the error flag
    a_ref_range: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE1
        ref_r >= REF_MIN && ref_r <= REF_MAX) else $error("reference out of range");
    a_ref_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE1
        (ref_write_i && !ref_valid) |=> $stable(ref_r) && command_error_o)
        else $error("bad ref stored");
    a_ref_take: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE2
        (ref_write_i && ref_valid) |=> sequence_reference_o == $past(ref_value_i))
        else $error("reference not taken");
    a_part_min: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE4
        part_r == '0 || popcount(part_r) >= MIN_PART) else $error("too few participants");
    a_part_refuse: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE4
        (part_write_i && !part_clear_i && !part_valid) |=> $stable(part_r) && command_error_o)
        else $error("bad participant set stored");
    a_error_quiet: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE1 RULE4
        (!ref_write_i && !part_write_i) |=> !command_error_o) else $error("spurious error");
    a_clear_all: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE6
        part_clear_i |=> part_r == '0) else $error("clear failed");
    a_dir_take: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE11
        dir_write_i |=> dir_r == $past(dir_value_i)) else $error("direction lost");
    a_delay_take: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE10
        delay_write_i |=> channel_delay_o == $past(delay_value_i)) else $error("delay lost");

    // sequencing: counters load at the transition, expiry switches in the programmed direction
    a_nonpart_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE15
        (!switch_write_i && !part_r[0]) |=> $stable(out_r[0])) else $error("ch1 moved");
    a_load_count: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE16
        (start_seq && part_r[1] && ref_r != 2'h2) |=> pend_r[1] && cnt_r[1] == $past(delay_r[1]))
        else $error("counter not loaded");
    a_expire_out: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE13
        (pend_r[2] && cnt_r[2] == DELAY_ZERO && !switch_write_i) |=> out_r[2] == $past(dir_r)
        && !pend_r[2]) else $error("follower not switched");
    a_zero_delay: assert property (@(posedge mclk_i) disable iff (reset_i) // RULE14
        (start_seq && part_r[1] && ref_r != 2'h2 && delay_r[1] == DELAY_ZERO && !dir_r)
        |=> !switch_write_i |=> !out_r[1]) else $error("off late");
endmodule
`default_nettype wire

//--- delay_seq_pkg.sv
/*
 * constants for the output on/off delay sequencer: channel count, field widths,
 * millisecond tick timing and reset values.
 * assumes a single 50 MHz system clock.
 */
`default_nettype none
package delay_seq_pkg;
    localparam int          NUM_CH        = 3;
    localparam int          DELAY_W       = 16;
    localparam int          CLK_HZ        = 50_000_000;
    localparam int          TICK_MS       = 1;
    localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    localparam int          TICK_W        = 16;
    localparam logic [1:0]  REF_RESET     = 2'h1;
    localparam logic [1:0]  REF_MIN       = 2'h1;
    localparam logic [1:0]  REF_MAX       = 2'h3;
    localparam logic [2:0]  PART_RESET    = 3'h0;
    localparam logic        DIR_RESET     = 1'b1;
    localparam logic [15:0] DELAY_ZERO    = 16'h0000;
    localparam int          MIN_PART      = 2;
endpackage
`default_nettype wire

//--- ms_tick_gen.sv
/*
 * millisecond tick generator: one-cycle pulse every TICK_CYCLES clocks.
 * assumes mclk_i at the package clock rate; restart realigns the tick to a
 * reference transition so each delay is accurate to two clock cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen
    import delay_seq_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic reset_i,
    input  wire logic restart_i,
    output logic      tick_o
);
    localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_CYCLES - 1);
    logic [TICK_W-1:0] cnt_r;

    // free-running divider, realigned on restart
    always_ff @(posedge mclk_i) begin
        if (reset_i || restart_i) begin
            cnt_r  <= '0;
            tick_o <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r  <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- host_cmd_model.sv
/* host side of the sequencer: issues one command at a time.
   assumes one strobe bit per command kind and a shared value bus. */
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model
(
    input  wire logic        mclk_i,
    output logic [5:0]       strobe_o,
    output logic [47:0]      value_o,
    output logic [1:0]       chan_o
);
    // quiet bus at time zero
    initial begin
        strobe_o = 6'h00;
        value_o  = 48'h0;
        chan_o   = 2'h0;
    end

    // raise after an edge, hold through the taking edge, then release
    task automatic issue(input int kind, input logic [47:0] v, input logic [1:0] ch);
        @(posedge mclk_i);
        strobe_o <= 6'(1 << kind);
        value_o  <= v;
        chan_o   <= ch;
        @(posedge mclk_i);
        strobe_o <= 6'h00;
        value_o  <= ~v; // a released bus must not keep its last value
        chan_o   <= ~ch;
    endtask
endmodule
`default_nettype wire

//--- test_output_on_off_delay_sequencer.sv
/* bench for the delay sequencer: a model kept in integers is compared at every result.
   assumes host_cmd_model and the package millisecond tick. */
`timescale 1ns/1ps
`default_nettype none
module test_output_on_off_delay_sequencer
    import delay_seq_pkg::*;
;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    wire  [5:0]  stb;
    wire  [47:0] val;
    wire  [1:0]  chn;
    logic [1:0]  ref_o;
    logic [2:0]  part_o, out_o, pend_o;
    logic [47:0] dly_o, dly_m;
    logic        dir_o, err_o;
    int          fail_count = 0;
    int          n_checks = 0;
    int          ref_m, part_m, dir_m, out_m, pend_m, k, t, ok;

    always #10 mclk_i = ~mclk_i;

    host_cmd_model host (.mclk_i, .strobe_o(stb), .value_o(val), .chan_o(chn));

    output_on_off_delay_sequencer uut (
        .mclk_i, .reset_i, .ref_write_i(stb[0]), .ref_value_i(val[1:0]),
        .part_write_i(stb[1]), .part_value_i(val[2:0]), .part_clear_i(stb[2]),
        .delay_write_i(stb[3]), .delay_value_i(val), .dir_write_i(stb[4]),
        .dir_value_i(val[0]), .switch_write_i(stb[5]), .switch_channel_i(chn),
        .switch_value_i(val[0]), .sequence_reference_o(ref_o),
        .sequence_participant_o(part_o), .channel_delay_o(dly_o),
        .sequence_direction_o(dir_o), .channel_output_o(out_o),
        .channel_pending_o(pend_o), .command_error_o(err_o));

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    // every status output against the model
    task automatic chk_all(input logic e);
        chk(ref_o, 48'(ref_m), "ref");
        chk(part_o, 48'(part_m), "part");
        chk(dly_o, dly_m, "delay");
        chk(dir_o, 48'(dir_m), "dir");
        chk(out_o, 48'(out_m), "out");
        chk(err_o, e, "error");
        chk(pend_o, 48'(pend_m), "pending");
    endtask

    // error pulse stands one cycle, so look 1 ns after the taking edge
    task automatic cmd(input int kind, input logic [47:0] v, input logic [1:0] ch);
        host.issue(kind, v, ch);
        #1;
    endtask

    // follower must move d ms after the reference, within a few cycles
    task automatic wait_out(input int idx, input logic v, input int d);
        t = 0;
        while (out_o[idx] !== v && t < d * TICK_CYCLES + 4) begin
            @(posedge mclk_i);
            #1;
            t++;
        end
        chk(48'(t >= d * TICK_CYCLES - 2 && t < d * TICK_CYCLES + 4), 48'h1, "timing");
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        k = $urandom(32'h95ada780);
        {ref_m, part_m, dir_m, out_m} = {32'd1, 32'd0, 32'd1, 32'd0};
        pend_m = 0;
        dly_m = 48'h0;
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        chk_all(1'b0);
        $display("reset test done");
        // every reference code, 0 refused and old value kept
        for (k = 3; k >= 0; k--) begin
            cmd(0, 48'(k), 2'h0);
            if (k != 0) ref_m = k;
            chk_all(k == 0);
        end
        // random participant sets against a random reference
        repeat (16) begin
            t = $urandom_range(3, 1);
            cmd(0, 48'(t), 2'h0);
            ref_m = t;
            k = $urandom_range(7, 0);
            cmd(1, 48'(k), 2'h0);
            ok = ($countones(k[2:0]) >= 2) && k[t-1];
            if (ok) part_m = k;
            chk_all(!ok);
        end
        cmd(2, 48'h0, 2'h0);
        part_m = 0;
        chk_all(1'b0);
        dly_m = 48'({$urandom(), $urandom()});
        cmd(3, dly_m, 2'h0);
        chk_all(1'b0);
        for (k = 0; k < 2; k++) begin
            cmd(4, 48'(k), 2'h0);
            dir_m = k;
            chk_all(1'b0);
        end
        $display("settings test done");
        // turn-on: ch3 left out of the set but carries a stale delay
        cmd(0, 48'h1, 2'h0);
        cmd(1, 48'h3, 2'h0);
        {ref_m, part_m} = {32'd1, 32'd3};
        dly_m = {16'h0005, 16'h0000, 16'h0000};
        cmd(3, dly_m, 2'h0);
        cmd(5, 48'h1, 2'h1);
        {out_m, pend_m} = {32'd1, 32'd2};
        chk_all(1'b0);
        wait_out(1, 1'b1, 0);
        {out_m, pend_m} = {32'd3, 32'd0};
        chk_all(1'b0);
        $display("turn-on test done");
        // turn-off: ch3 switched directly while it is not the reference starts nothing
        cmd(4, 48'h0, 2'h0);
        cmd(5, 48'h1, 2'h3);
        cmd(0, 48'h3, 2'h0);
        cmd(1, 48'h6, 2'h0);
        {dir_m, out_m, ref_m, part_m} = {32'd0, 32'd7, 32'd3, 32'd6};
        dly_m = {16'h0000, 16'h0001, 16'h0000};
        cmd(3, dly_m, 2'h0);
        chk_all(1'b0);
        cmd(5, 48'h0, 2'h3);
        {out_m, pend_m} = {32'd3, 32'd2};
        chk_all(1'b0);
        wait_out(1, 1'b0, 1);
        {out_m, pend_m} = {32'd1, 32'd0};
        chk_all(1'b0);
        $display("turn-off test done");
        // zero follower delays; reference moves against the direction start nothing
        cmd(5, 48'h1, 2'h2);
        cmd(5, 48'h1, 2'h3);
        cmd(0, 48'h1, 2'h0);
        cmd(1, 48'h7, 2'h0);
        cmd(3, 48'h0, 2'h0);
        cmd(4, 48'h1, 2'h0);
        cmd(5, 48'h0, 2'h1);
        {ref_m, part_m, dir_m, out_m} = {32'd1, 32'd7, 32'd1, 32'd6};
        dly_m = 48'h0;
        chk_all(1'b0);
        cmd(4, 48'h0, 2'h0);
        cmd(5, 48'h1, 2'h1);
        {dir_m, out_m} = {32'd0, 32'd7};
        chk_all(1'b0);
        cmd(5, 48'h0, 2'h1);
        {out_m, pend_m} = {32'd6, 32'd6};
        chk_all(1'b0);
        wait_out(1, 1'b0, 0);
        wait_out(2, 1'b0, 0);
        {out_m, pend_m} = {32'd0, 32'd0};
        chk_all(1'b0);
        $display("zero-delay test done");
        give_verdict();
    end

    // whole run is about 50150 cycles; cut a hang well past that
    initial begin
        repeat (60000) @(posedge mclk_i);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
